// *** hdl/cwdm_config_regs.sv ***
// CW path and demodulator configuration bank with serial port and output formatter.
// Function
// - Five-bit gain field; bits weight 250, 250, 500, 1000, 2000 ohm, parallel.
// - Gain equals parallel resistance over 500 ohm; all-zero code has no gain.
// - Eight 4-bit phase codes, channels one-four then five-eight, nibble by nibble.
// - Phase code n shifts the mixing phase by n times 22.5 degrees.
// - Writing one to the trigger bit makes one internal transmit trigger pulse.
// - Write-only readback enable makes reads drive data on the readback pin.
// - Pattern select: 000 normal, 011 fixed test word, 111 tag plus ramp with the demodulator on, else normal.
// - Tag-ramp word carries tag and sub-die in low byte, ramp above it.
// - Five-bit unit tag register resets to zero.
// - Ratio field 01, 10, 11 give 12, 14, 16 bits; reset is 11.
// - Width field: 000 14 bits, 001 13, 010 12, 100 16 with the demodulator on, else 14.
// - Bit order bit: zero sends LSB first, one sends MSB first.
// - Fixed test word always goes out LSB first.
// - Top two address bits pick sub-die; 11 writes both.
// - Sixteen-bit fixed test word register, reset zero.
module cwdm_config_regs
   import cwdm_pkg::*;
#(
   parameter logic DIE_ID = 1'b0
)
(
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic        serial_clk_i,
   input  wire logic        serial_enable_n_i,
   input  wire logic        serial_data_i,
   output logic             serial_readback_pin_o,
   input  wire logic        demod_enable_i,
   input  wire logic [15:0] sample_i,
   output logic             transmit_trigger_o,
   output logic             readback_enable_o,
   output logic [4:0]       sum_gain_code_o,
   output logic [10:0]      sum_gain_q8_o,
   output logic             sum_gain_valid_o,
   output logic [31:0]      mixer_phase_code_o,
   output logic [95:0]      mixer_phase_deci_deg_o,
   output logic [2:0]       output_pattern_o,
   output logic [1:0]       serializer_ratio_o,
   output logic [2:0]       output_width_o,
   output logic             msb_first_o,
   output logic             serial_data_o,
   output logic             serial_frame_o
);

   cwdm_spi_state_t state;
   logic [2:0]  pin_raw, pin_s1, pin_s2, pin_s3, pin_f, eff_pattern;
   logic        sclk_prev, sclk_rise, sclk_fall, frame_end, die_hit, wr_pulse;
   logic        ser_load, ser_msb_first;
   logic [4:0]  bit_cnt, unit_tag, gain_cond, width_bits;
   logic [7:0]  rx_addr, ramp;
   logic [5:0]  wr_addr;
   logic [15:0] rx_data, rd_shift, wr_data, custom_word, read_word, width_mask, ser_word;

   // Pins pass three flops; a new level counts once the second and third agree.
   assign pin_raw = {serial_clk_i, serial_enable_n_i, serial_data_i};
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk_sys_i) begin
         if (reset_i) begin
            pin_s1[i] <= PIN_IDLE[i];
            pin_s2[i] <= PIN_IDLE[i];
            pin_s3[i] <= PIN_IDLE[i];
            pin_f[i]  <= PIN_IDLE[i];
         end else begin
            pin_s1[i] <= pin_raw[i];
            pin_s2[i] <= pin_s1[i];
            pin_s3[i] <= pin_s2[i];
            if (pin_s2[i] == pin_s3[i]) begin
               pin_f[i] <= pin_s3[i];
            end
         end
      end
   end

   // Serial clock edges seen in the system clock domain.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= pin_f[2];
      end
   end
   assign sclk_rise = pin_f[2] & ~sclk_prev;
   assign sclk_fall = ~pin_f[2] & sclk_prev;
   assign frame_end = pin_f[1] & (state == SPI_DATA) & (bit_cnt == BITS_16);

   // Frame sequencer: address bits, then data bits; a short frame is dropped.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state   <= SPI_IDLE;
         bit_cnt <= 5'h00;
         rx_addr <= 8'h00;
         rx_data <= 16'h0000;
      end else begin
         case (state)
            SPI_IDLE: begin
               bit_cnt <= 5'h00;
               if (!pin_f[1]) begin
                  state <= SPI_ADDR;
               end
            end
            SPI_ADDR: begin
               if (pin_f[1]) begin
                  state <= SPI_IDLE;
               end else if (sclk_rise) begin
                  rx_addr <= {rx_addr[6:0], pin_f[0]};
                  if (bit_cnt == 5'h07) begin
                     bit_cnt <= 5'h00;
                     state   <= SPI_DATA;
                  end else begin
                     bit_cnt <= bit_cnt + 5'h01;
                  end
               end
            end
            SPI_DATA: begin
               if (pin_f[1]) begin
                  state <= SPI_IDLE;
               end else if (sclk_rise && (bit_cnt != BITS_16)) begin
                  rx_data <= {rx_data[14:0], pin_f[0]};
                  bit_cnt <= bit_cnt + 5'h01;
               end
            end
            default: begin
               state <= SPI_IDLE;
            end
         endcase
      end
   end

   // Both sub-dies take code 11; each single code reaches only its own die.
   always_comb begin
      case (rx_addr[7:6])
         DIE_BOTH: die_hit = 1'b1;
         DIE_HIGH: die_hit = DIE_ID;
         DIE_LOW:  die_hit = ~DIE_ID;
         default:  die_hit = 1'b0;
      endcase
   end

   // A completed frame becomes one write pulse; in readback mode only offset 0 is written,
   // so a read frame cannot disturb the register it reads.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         wr_pulse <= 1'b0;
         wr_addr  <= 6'h00;
         wr_data  <= 16'h0000;
      end else begin
         wr_pulse <= frame_end & die_hit &
                     (~readback_enable_o | (rx_addr[5:0] == OFS_TRIGGER));
         wr_addr  <= rx_addr[5:0];
         wr_data  <= rx_data;
      end
   end

   // Register readout: the word is loaded after the address and leaves on falling edges.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rd_shift              <= 16'h0000;
         serial_readback_pin_o <= 1'b0;
      end else if (!readback_enable_o || state != SPI_DATA) begin
         serial_readback_pin_o <= 1'b0;
         if (state == SPI_ADDR && sclk_rise && bit_cnt == 5'h07) begin
            rd_shift <= read_word;
         end
      end else if (sclk_fall) begin
         serial_readback_pin_o <= rd_shift[15];
         rd_shift              <= {rd_shift[14:0], 1'b0};
      end
   end

   // Offset 0 is write-only: trigger self clears, readback enable holds.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         transmit_trigger_o <= 1'b0;
         readback_enable_o  <= 1'b0;
      end else begin
         transmit_trigger_o <= wr_pulse & (wr_addr == OFS_TRIGGER) & wr_data[TRIGGER_BIT];
         if (wr_pulse && wr_addr == OFS_TRIGGER) begin
            readback_enable_o <= wr_data[READBACK_BIT];
         end
      end
   end

   // Demodulator control registers.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         unit_tag           <= TAG_RESET;
         output_pattern_o   <= PATTERN_RESET;
         serializer_ratio_o <= RATIO_RESET;
         output_width_o     <= WIDTH_RESET;
         msb_first_o        <= ORDER_RESET;
         custom_word        <= CUSTOM_RESET;
      end else if (wr_pulse) begin
         case (wr_addr)
            OFS_TAG:     unit_tag <= wr_data[TAG_LSB +: 5];
            OFS_PATTERN: output_pattern_o <= wr_data[PATTERN_LSB +: 3];
            OFS_FORMAT: begin
               serializer_ratio_o <= wr_data[RATIO_LSB +: 2];
               output_width_o     <= wr_data[WIDTH_LSB +: 3];
            end
            OFS_ORDER:   msb_first_o <= wr_data[ORDER_BIT];
            OFS_CUSTOM:  custom_word <= wr_data;
            default: ;
         endcase
      end
   end

   // CW path registers.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sum_gain_code_o    <= GAIN_RESET;
         mixer_phase_code_o <= PHASE_RESET;
      end else if (wr_pulse) begin
         case (wr_addr)
            OFS_GAIN:     sum_gain_code_o <= wr_data[GAIN_LSB +: 5];
            OFS_PHASE_LO: mixer_phase_code_o[15:0] <= wr_data;
            OFS_PHASE_HI: mixer_phase_code_o[31:16] <= wr_data;
            default: ;
         endcase
      end
   end

   // Readback map; write-only offset and unlisted bits read as zero.
   always_comb begin
      read_word = 16'h0000;
      case ({rx_addr[4:0], pin_f[0]}) // The last address bit is still on the pin at load.
         OFS_TAG:      read_word[TAG_LSB +: 5] = unit_tag;
         OFS_PATTERN:  read_word[PATTERN_LSB +: 3] = output_pattern_o;
         OFS_FORMAT: begin
            read_word[RATIO_LSB +: 2] = serializer_ratio_o;
            read_word[WIDTH_LSB +: 3] = output_width_o;
         end
         OFS_ORDER:    read_word[ORDER_BIT] = msb_first_o;
         OFS_CUSTOM:   read_word = custom_word;
         OFS_GAIN:     read_word[GAIN_LSB +: 5] = sum_gain_code_o;
         OFS_PHASE_LO: read_word = mixer_phase_code_o[15:0];
         OFS_PHASE_HI: read_word = mixer_phase_code_o[31:16];
         default:      read_word = 16'h0000;
      endcase
   end

   // Parallel feedback network as total conductance; gain is its inverse scaled to 500 ohm.
   assign gain_cond = (sum_gain_code_o[0] ? COND_250 : 5'h00)
                    + (sum_gain_code_o[1] ? COND_250 : 5'h00)
                    + (sum_gain_code_o[2] ? COND_500 : 5'h00)
                    + (sum_gain_code_o[3] ? COND_1000 : 5'h00)
                    + (sum_gain_code_o[4] ? COND_2000 : 5'h00);
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sum_gain_q8_o    <= 11'h000;
         sum_gain_valid_o <= 1'b0;
      end else begin
         sum_gain_valid_o <= (gain_cond != 5'h00);
         sum_gain_q8_o    <= (gain_cond == 5'h00) ? 11'h000 : GAIN_NUM / {6'h00, gain_cond};
      end
   end

   // Phase shift per channel in tenths of a degree.
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_phase
      always_ff @(posedge clk_sys_i) begin
         if (reset_i) begin
            mixer_phase_deci_deg_o[ch*12 +: 12] <= 12'h000;
         end else begin
            mixer_phase_deci_deg_o[ch*12 +: 12] <=
               {8'h00, mixer_phase_code_o[ch*PHASE_W +: PHASE_W]} * PHASE_STEP;
         end
      end
   end

   // Effective pattern: reserved codes and tag-ramp without the demodulator give normal data.
   always_comb begin
      if (output_pattern_o == PAT_CUSTOM) begin
         eff_pattern = PAT_CUSTOM;
      end else if (output_pattern_o == PAT_TAG_RAMP && demod_enable_i) begin
         eff_pattern = PAT_TAG_RAMP;
      end else begin
         eff_pattern = PAT_NORMAL;
      end
   end

   // Significant bits of normal data; 16 bits only makes sense behind the demodulator.
   always_comb begin
      case (output_width_o)
         WIDTH_13: width_bits = BITS_13;
         WIDTH_12: width_bits = BITS_12;
         WIDTH_16: width_bits = demod_enable_i ? BITS_16 : BITS_14;
         default:  width_bits = BITS_14;
      endcase
   end
   assign width_mask = 16'hffff >> (BITS_16 - width_bits);

   // Ramp advances once per word taken in tag-ramp mode.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ramp <= 8'h00;
      end else if (ser_load && eff_pattern == PAT_TAG_RAMP) begin
         ramp <= ramp + 8'h01;
      end
   end

   // Word handed to the serializer.
   always_comb begin
      case (eff_pattern)
         PAT_CUSTOM:   ser_word = custom_word;
         PAT_TAG_RAMP: ser_word = {ramp, unit_tag, 2'h0, DIE_ID};
         default:      ser_word = sample_i & width_mask;
      endcase
   end

   // The fixed test word ignores the order bit.
   assign ser_msb_first = msb_first_o & (eff_pattern != PAT_CUSTOM);

   cwdm_serializer u_serializer (
      .clk_sys_i   (clk_sys_i),
      .reset_i     (reset_i),
      .word_i      (ser_word),
      .ratio_i     (serializer_ratio_o),
      .msb_first_i (ser_msb_first),
      .load_o      (ser_load),
      .bit_o       (serial_data_o),
      .frame_o     (serial_frame_o)
   );

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   sequence trig_write_s;
      wr_pulse && wr_addr == OFS_TRIGGER && wr_data[TRIGGER_BIT];
   endsequence
   sequence trig_pulse_s;
      transmit_trigger_o ##1 !transmit_trigger_o;
   endsequence
   sequence custom_load_s;
      ser_load && eff_pattern == PAT_CUSTOM;
   endsequence

   trig_pulse_a: assert property (trig_write_s |=> trig_pulse_s)
      else $error("soft trigger did not give a single pulse");
   die_filter_a: assert property (frame_end && rx_addr[7:6] == 2'h0 |=> !wr_pulse)
      else $error("write taken with no sub-die selected");
   readback_idle_a: assert property (!readback_enable_o && !$past(readback_enable_o)
                                     |-> !serial_readback_pin_o)
      else $error("readback pin driven while readback disabled");
   gain_unity_a: assert property (sum_gain_code_o == 5'h04 |=> sum_gain_q8_o == 11'h100)
      else $error("gain for 500 ohm is not 1.00");
   gain_none_a: assert property (sum_gain_code_o == 5'h00 |=> !sum_gain_valid_o)
      else $error("gain flagged valid with no resistor");
   phase_max_a: assert property (mixer_phase_code_o[15:12] == 4'hf
                                 |=> mixer_phase_deci_deg_o[47:36] == 12'hd2f)
      else $error("phase code 15 is not 337.5 degrees");
   ratio_reset_a: assert property ($fell(reset_i) |-> serializer_ratio_o == 2'h3)
      else $error("serializer ratio reset value wrong");
   frame_gap_a: assert property (ser_load |=> !ser_load [*8])
      else $error("serializer word shorter than allowed");
   custom_lsb_a: assert property (custom_load_s |=> serial_data_o == $past(custom_word[0]))
      else $error("test word not sent LSB first");
   tag_ramp_a: assert property (ser_load && eff_pattern == PAT_TAG_RAMP
                                |-> ser_word[7:3] == unit_tag)
      else $error("tag missing from tag-ramp word");
   custom_store_a: assert property (wr_pulse && wr_addr == OFS_CUSTOM
                                    |=> custom_word == $past(wr_data))
      else $error("test word register did not take the write");

endmodule : cwdm_config_regs

// *** hdl/cwdm_pkg.sv ***
// Package with offsets, field positions, reset values and codes of the CW and demodulator bank.
package cwdm_pkg;

   // Serial frame layout: eight address bits, then sixteen data bits, MSB first.
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 16;
   localparam int FRAME_BITS = 24;

   // Register offsets within the six low address bits.
   localparam logic [5:0] OFS_TRIGGER  = 6'h00;
   localparam logic [5:0] OFS_TAG      = 6'h01;
   localparam logic [5:0] OFS_PATTERN  = 6'h02;
   localparam logic [5:0] OFS_FORMAT   = 6'h03;
   localparam logic [5:0] OFS_ORDER    = 6'h04;
   localparam logic [5:0] OFS_CUSTOM   = 6'h05;
   localparam logic [5:0] OFS_GAIN     = 6'h36;
   localparam logic [5:0] OFS_PHASE_LO = 6'h37;
   localparam logic [5:0] OFS_PHASE_HI = 6'h38;

   // Field positions.
   localparam int TRIGGER_BIT  = 2;
   localparam int READBACK_BIT = 1;
   localparam int TAG_LSB      = 0;
   localparam int PATTERN_LSB  = 13;
   localparam int RATIO_LSB    = 13;
   localparam int WIDTH_LSB    = 9;
   localparam int ORDER_BIT    = 4;
   localparam int GAIN_LSB     = 0;

   // Values after reset.
   localparam logic [4:0]  TAG_RESET     = 5'h00;
   localparam logic [2:0]  PATTERN_RESET = 3'h0;
   localparam logic [1:0]  RATIO_RESET   = 2'h3;
   localparam logic [2:0]  WIDTH_RESET   = 3'h0;
   localparam logic        ORDER_RESET   = 1'b0;
   localparam logic [15:0] CUSTOM_RESET  = 16'h0000;
   localparam logic [4:0]  GAIN_RESET    = 5'h00;
   localparam logic [31:0] PHASE_RESET   = 32'h0000_0000;
   localparam logic [2:0]  PIN_IDLE      = 3'h2;

   // Output pattern codes.
   localparam logic [2:0] PAT_NORMAL   = 3'h0;
   localparam logic [2:0] PAT_CUSTOM   = 3'h3;
   localparam logic [2:0] PAT_TAG_RAMP = 3'h7;

   // Serializer ratio codes and bits per word.
   localparam logic [1:0] RATIO_RSVD = 2'h0;
   localparam logic [1:0] RATIO_12   = 2'h1;
   localparam logic [1:0] RATIO_14   = 2'h2;
   localparam logic [1:0] RATIO_16   = 2'h3;
   localparam logic [4:0] BITS_12    = 5'h0c;
   localparam logic [4:0] BITS_14    = 5'h0e;
   localparam logic [4:0] BITS_16    = 5'h10;
   localparam logic [4:0] BITS_13    = 5'h0d;

   // Output word width codes.
   localparam logic [2:0] WIDTH_14 = 3'h0;
   localparam logic [2:0] WIDTH_13 = 3'h1;
   localparam logic [2:0] WIDTH_12 = 3'h2;
   localparam logic [2:0] WIDTH_16 = 3'h4;

   // Sub-die select codes in the two top address bits.
   localparam logic [1:0] DIE_BOTH = 2'h3;
   localparam logic [1:0] DIE_HIGH = 2'h2;
   localparam logic [1:0] DIE_LOW  = 2'h1;

   // Feedback conductances in units of 1/2000 siemens, and gain numerator in Q8.
   localparam logic [4:0]  COND_250  = 5'h08;
   localparam logic [4:0]  COND_500  = 5'h04;
   localparam logic [4:0]  COND_1000 = 5'h02;
   localparam logic [4:0]  COND_2000 = 5'h01;
   localparam logic [10:0] GAIN_NUM  = 11'h400;

   // Mixer phase step in tenths of a degree.
   localparam int          NUM_CH     = 8;
   localparam int          PHASE_W    = 4;
   localparam logic [11:0] PHASE_STEP = 12'h0e1;

   typedef enum logic [2:0] {
      SPI_IDLE = 3'b001,
      SPI_ADDR = 3'b010,
      SPI_DATA = 3'b100
   } cwdm_spi_state_t;

endpackage : cwdm_pkg

// *** hdl/cwdm_serializer.sv ***
// Output serializer: shifts one word per frame at the selected ratio and bit order.
module cwdm_serializer
   import cwdm_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic [15:0] word_i,
   input  wire logic [1:0]  ratio_i,
   input  wire logic        msb_first_i,
   output logic             load_o,
   output logic             bit_o,
   output logic             frame_o
);

   logic [4:0]  bit_idx;
   logic [4:0]  frame_len;
   logic [15:0] shreg;
   logic [15:0] aligned;
   logic        msb_mode;

   // The reserved ratio code falls back to sixteen bits.
   always_comb begin
      case (ratio_i)
         RATIO_12: frame_len = BITS_12;
         RATIO_14: frame_len = BITS_14;
         default:  frame_len = BITS_16;
      endcase
   end

   // Left-align the word so the MSB of the frame sits in bit 15.
   assign aligned = word_i << (BITS_16 - frame_len);
   assign load_o  = (bit_idx >= (frame_len - 5'h01)); // A shorter ratio ends the word at once.

   // The order is latched per word so a mid-frame change cannot scramble a word.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         bit_idx  <= 5'h00;
         shreg    <= 16'h0000;
         msb_mode <= 1'b0;
         bit_o    <= 1'b0;
         frame_o  <= 1'b0;
      end else if (load_o) begin
         bit_idx  <= 5'h00;
         msb_mode <= msb_first_i;
         bit_o    <= msb_first_i ? aligned[15] : word_i[0];
         shreg    <= msb_first_i ? (aligned << 1) : (word_i >> 1);
         frame_o  <= 1'b1;
      end else begin
         bit_idx  <= bit_idx + 5'h01;
         bit_o    <= msb_mode ? shreg[15] : shreg[0];
         shreg    <= msb_mode ? (shreg << 1) : (shreg >> 1);
         frame_o  <= 1'b0;
      end
   end

endmodule : cwdm_serializer

// *** tb/cwdm_host_model.sv ***
// Serial configuration host model that drives write frames into the register bank.
module cwdm_host_model (
   input  wire logic clk_i,
   input  wire logic readback_i,
   output logic      sclk_o,
   output logic      sen_n_o,
   output logic      sdata_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // Readback bits seen during the data part of the last frame, MSB first.
   logic [15:0] rd_word = 16'h0000;

   // The serial clock idles low between frames and only moves inside a frame.
   initial begin
      sclk_o = 1'b0;
      sen_n_o = 1'b1;
      sdata_o = 1'b0;
   end

   // Waits whole system cycles and then steps just past the edge.
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : hold

   // Sends the die select, offset and data MSB first; phases of five cycles beat the filter.
   task automatic send(input logic [7:0] addr, input logic [15:0] data);
      logic [23:0] frame;
      frame = {addr, data};
      sen_n_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdata_o = frame[i];
         hold(5);
         if (i < 16) rd_word[i] = readback_i;
         sclk_o = 1'b1;
         hold(5);
         sclk_o = 1'b0;
      end
      hold(5);
      sen_n_o = 1'b1;
      sdata_o = ~frame[0];
      hold(12);
   endtask : send
endmodule : cwdm_host_model

// *** tb/cw_and_demod_config_regs_tb.sv ***
// Self-checking bench of the CW and demodulator configuration bank.
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module cw_and_demod_config_regs_tb
   import cwdm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_sys = 1'b0;
   logic        reset, sclk, sen_n, sdata, demod_en, trig, rb_en, gain_ok, msb_first;
   logic        ser_data, ser_frame, rb_pin;
   logic [15:0] sample, w1, w2;
   logic [4:0]  gain_code;
   logic [10:0] gain_q8;
   logic [31:0] phase;
   logic [95:0] deci;
   logic [2:0]  pattern, width;
   logic [1:0]  ratio;
   int          err_total = 0, n_tests = 0, trig_cnt = 0;

   // The host model stands in for the serial configuration controller.
   cwdm_host_model host_u (.clk_i(clk_sys), .readback_i(rb_pin), .sclk_o(sclk),
                           .sen_n_o(sen_n), .sdata_o(sdata));

   cwdm_config_regs #(.DIE_ID(1'b0)) dut_u (
      .clk_sys_i(clk_sys), .reset_i(reset), .serial_clk_i(sclk), .serial_enable_n_i(sen_n),
      .serial_data_i(sdata), .serial_readback_pin_o(rb_pin), .demod_enable_i(demod_en),
      .sample_i(sample), .transmit_trigger_o(trig), .readback_enable_o(rb_en),
      .sum_gain_code_o(gain_code), .sum_gain_q8_o(gain_q8), .sum_gain_valid_o(gain_ok),
      .mixer_phase_code_o(phase), .mixer_phase_deci_deg_o(deci), .output_pattern_o(pattern),
      .serializer_ratio_o(ratio), .output_width_o(width), .msb_first_o(msb_first),
      .serial_data_o(ser_data), .serial_frame_o(ser_frame));

   // Clock and a running count of trigger pulses, so a double pulse cannot hide.
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (trig === 1'b1) trig_cnt++;
   end

   task automatic wr(input logic [5:0] ofs, input logic [15:0] d);
      host_u.send({DIE_BOTH, ofs}, d);
   endtask : wr

   // Collects one serialized word in arrival order, so bit 0 is the first bit on the wire.
   task automatic capture(output logic [15:0] w);
      int k;
      k = 0;
      while (ser_frame !== 1'b1 && k < 100) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      for (int i = 0; i < 16; i++) begin
         w[i] = ser_data;
         @(posedge clk_sys);
         #1;
      end
   endtask : capture

   task automatic t_reset();
      `CHK("ratio", 2'h3, ratio)
      `CHK("pattern", 3'h0, pattern)
      `CHK("width", 3'h0, width)
      `CHK("msb_first", 1'b0, msb_first)
      `CHK("rb_en", 1'b0, rb_en)
      `CHK("trig", 1'b0, trig)
      `CHK("phase", 32'h0, phase)
   endtask : t_reset

   task automatic t_gain();
      logic [4:0]  code [5] = '{5'h04, 5'h08, 5'h10, 5'h1f, 5'h01};
      logic [10:0] q8   [5] = '{11'h100, 11'h200, 11'h400, 11'h02c, 11'h080};
      for (int i = 0; i < 5; i++) begin
         wr(OFS_GAIN, {11'h000, code[i]});
         `CHK("gain_code", code[i], gain_code)
         `CHK("gain_q8", q8[i], gain_q8)
         `CHK("gain_ok", 1'b1, gain_ok)
      end
      wr(OFS_GAIN, 16'h0000);
      `CHK("gain_ok", 1'b0, gain_ok)
   endtask : t_gain

   // Select 00 and the other die's code must both be ignored by this die.
   task automatic t_die();
      host_u.send({2'b00, OFS_GAIN}, 16'h0002);
      `CHK("gain_code", 5'h00, gain_code)
      host_u.send({DIE_HIGH, OFS_GAIN}, 16'h0003);
      `CHK("gain_code", 5'h00, gain_code)
      host_u.send({DIE_LOW, OFS_GAIN}, 16'h0003);
      `CHK("gain_code", 5'h03, gain_code)
   endtask : t_die

   task automatic t_phase();
      wr(OFS_PHASE_LO, 16'hf310);
      wr(OFS_PHASE_HI, 16'h8421);
      `CHK("phase", 32'h8421_f310, phase)
      `CHK("deg_ch4", 12'hd2f, deci[47:36])
      `CHK("deg_ch8", 12'h708, deci[95:84])
      `CHK("deg_ch1", 12'h000, deci[11:0])
   endtask : t_phase

   task automatic t_trig();
      int c0;
      c0 = trig_cnt;
      wr(OFS_TRIGGER, 16'h0004);
      `CHK("trig_pulses", 1, trig_cnt - c0)
   endtask : t_trig

   // Each ratio code paired with one width code, ending on 16x and 14 bits.
   task automatic t_fmt();
      logic [2:0] wc [4] = '{WIDTH_16, WIDTH_12, WIDTH_13, WIDTH_14};
      for (int i = 0; i < 4; i++) begin
         wr(OFS_FORMAT, {1'b0, 2'(i), 1'b0, wc[i], 9'h000});
         `CHK("ratio", 2'(i), ratio)
         `CHK("width", wc[i], width)
      end
   endtask : t_fmt

   task automatic t_custom();
      wr(OFS_CUSTOM, 16'ha5c3);
      wr(OFS_ORDER, 16'h0010);
      `CHK("msb_first", 1'b1, msb_first)
      wr(OFS_PATTERN, 16'h6000);
      `CHK("pattern", PAT_CUSTOM, pattern)
      capture(w1);
      capture(w1);
      `CHK("custom_word", 16'ha5c3, w1)
   endtask : t_custom

   task automatic t_ramp();
      demod_en = 1'b1;
      wr(OFS_TAG, 16'h0015);
      wr(OFS_ORDER, 16'h0000);
      wr(OFS_PATTERN, 16'he000);
      capture(w1);
      capture(w1);
      capture(w2);
      `CHK("tag_byte", 8'ha8, w1[7:0])
      `CHK("ramp_step", w1[15:8] + 8'h01, w2[15:8])
      wr(OFS_PATTERN, 16'h2000);
      capture(w1);
      capture(w1);
      `CHK("normal_word", 16'h1234, w1)
      wr(OFS_ORDER, 16'h0010);
      capture(w1);
      capture(w1);
      `CHK("msb_word", 16'h2c48, w1)
   endtask : t_ramp

   // Readback mode blocks ordinary writes until it is switched off again.
   task automatic t_rb();
      wr(OFS_TRIGGER, 16'h0002);
      `CHK("rb_en", 1'b1, rb_en)
      wr(OFS_GAIN, 16'h0007);
      `CHK("gain_code", 5'h03, gain_code)
      `CHK("readback", 16'h0003, host_u.rd_word)
      wr(OFS_TRIGGER, 16'h0000);
      `CHK("rb_en", 1'b0, rb_en)
   endtask : t_rb

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   // Main sequence: five reset cycles, then the scenarios in turn.
   initial begin
      reset = 1'b1;
      demod_en = 1'b0;
      sample = 16'hd234;
      repeat (5) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      t_reset();
      t_gain();
      t_die();
      t_phase();
      t_trig();
      t_fmt();
      t_custom();
      t_ramp();
      t_rb();
      summarize();
   end

   // About thirty frames of 260 cycles are expected; this limit leaves ample margin.
   initial begin
      #500us;
      err_total++;
      summarize();
   end
endmodule : cw_and_demod_config_regs_tb
